/* design/sbs_pkg.sv */
// Shared constants and types for the boundary scan test data path.
// Assumes one TAP on the test clock and a slower-changing memory ring.
// Notes on behaviour
// - Sample data-in rising, change data-out falling.
// - Exactly one register sits between serial pins.
// - Three-bit instruction, active after Update-IR.
// - Identify instruction loaded at power-up and reset.
// - Capture-IR loads 01 into low bits.
// - One bypass bit, cleared when bypass executes.
// - Bypass routes data through one bit.
// - Capture-DR loads ring states, then shifts them.
// - One cell per ball; MSB faces data-in.
// - Identify captures hardwired 32-bit code.
// - Sample-high-Z selects ring, floats read bus.
// - Sample/preload selects ring and snapshots balls.
// - Preload latches pattern; capture and shift overlap.
// - Extest drives preloaded values onto pins.
// - Cell 108 latched at Update-DR enables read drivers under extest.
// - Drive control cell preset at power-up, reset.
// - Power-up reset leaves data-out high impedance.
package sbs_pkg;
	localparam int SBS_IR_W = 3;
	localparam int SBS_ID_W = 32;
	localparam int SBS_PIN_W = 108;
	localparam int SBS_BSR_W = 109;
	localparam int SBS_OUTCTL_BIT = 108;

	localparam logic [2:0] SBS_OP_EXTEST = 3'h0;
	localparam logic [2:0] SBS_OP_IDENT = 3'h1;
	localparam logic [2:0] SBS_OP_SAMPLE_Z = 3'h2;
	localparam logic [2:0] SBS_OP_PRELOAD = 3'h4;
	localparam logic [2:0] SBS_OP_BYPASS = 3'h7;

	localparam logic [2:0] SBS_IR_CAPTURE = 3'h1;
	localparam logic [2:0] SBS_IR_RESET = SBS_OP_IDENT;
	// Drive control cell preset to one: read drivers enabled
	localparam logic [108:0] SBS_BSR_RESET = 109'h1000000000000000000000000000;
	localparam logic [2:0] SBS_ID_REV = 3'h0;
	localparam logic [0:0] SBS_ID_START = 1'h1;
	localparam real SBS_TCK_MIN_PERIOD_NS = 50.0;

	typedef enum logic [15:0] {
		SBS_TLR = 16'h0001,
		SBS_RTI = 16'h0002,
		SBS_SEL_DR = 16'h0004,
		SBS_CAP_DR = 16'h0008,
		SBS_SH_DR = 16'h0010,
		SBS_EX1_DR = 16'h0020,
		SBS_PAU_DR = 16'h0040,
		SBS_EX2_DR = 16'h0080,
		SBS_UPD_DR = 16'h0100,
		SBS_SEL_IR = 16'h0200,
		SBS_CAP_IR = 16'h0400,
		SBS_SH_IR = 16'h0800,
		SBS_EX1_IR = 16'h1000,
		SBS_PAU_IR = 16'h2000,
		SBS_EX2_IR = 16'h4000,
		SBS_UPD_IR = 16'h8000
	} sbs_tap_state_t;
endpackage

/* design/sbs_scan_chain.sv */
// Capture/shift/update register with a latched parallel stage.
// Assumes strobes are single test clock states from the controller.
`timescale 1ns/1ps
module sbs_scan_chain #(
	parameter int W = 4,
	parameter logic [W-1:0] RST = {W{1'b0}}
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_en,
	input wire logic i_tlr,
	input wire logic i_capture,
	input wire logic i_shift,
	input wire logic i_update,
	input wire logic i_si,
	input wire logic [W-1:0] i_cap_val,
	output logic o_so,
	output logic [W-1:0] o_par
);
	logic [W-1:0] sh_r;
	logic [W-1:0] par_r;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sh_r <= RST;
		end else if (i_en && i_capture) begin
			sh_r <= i_cap_val;
		end else if (i_en && i_shift) begin
			sh_r <= {i_si, sh_r[W-1:1]};
		end
	end

	// Parallel stage holds while shifting, so old values keep driving
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			par_r <= RST;
		end else if (i_en && i_tlr) begin
			par_r <= RST;
		end else if (i_en && i_update) begin
			par_r <= sh_r;
		end
	end

	assign o_so = sh_r[0];
	assign o_par = par_r;
endmodule

/* design/sbs_tap_fsm.sv */
// TAP controller state machine on the test clock.
// Assumes mode select is already in the test clock domain.
`timescale 1ns/1ps
module sbs_tap_fsm
	import sbs_pkg::*;
(
	input wire logic i_tck,
	input wire logic i_resetn,
	input wire logic i_en,
	input wire logic i_tms,
	sbs_tap_if.ctl tap
);
	sbs_tap_state_t state_r;
	sbs_tap_state_t state_nxt;

	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= SBS_TLR;
		end else if (i_en) begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		case (state_r)
			SBS_TLR: state_nxt = i_tms ? SBS_TLR : SBS_RTI;
			SBS_RTI: state_nxt = i_tms ? SBS_SEL_DR : SBS_RTI;
			SBS_SEL_DR: state_nxt = i_tms ? SBS_SEL_IR : SBS_CAP_DR;
			SBS_CAP_DR: state_nxt = i_tms ? SBS_EX1_DR : SBS_SH_DR;
			SBS_SH_DR: state_nxt = i_tms ? SBS_EX1_DR : SBS_SH_DR;
			SBS_EX1_DR: state_nxt = i_tms ? SBS_UPD_DR : SBS_PAU_DR;
			SBS_PAU_DR: state_nxt = i_tms ? SBS_EX2_DR : SBS_PAU_DR;
			SBS_EX2_DR: state_nxt = i_tms ? SBS_UPD_DR : SBS_SH_DR;
			SBS_UPD_DR: state_nxt = i_tms ? SBS_SEL_DR : SBS_RTI;
			SBS_SEL_IR: state_nxt = i_tms ? SBS_TLR : SBS_CAP_IR;
			SBS_CAP_IR: state_nxt = i_tms ? SBS_EX1_IR : SBS_SH_IR;
			SBS_SH_IR: state_nxt = i_tms ? SBS_EX1_IR : SBS_SH_IR;
			SBS_EX1_IR: state_nxt = i_tms ? SBS_UPD_IR : SBS_PAU_IR;
			SBS_PAU_IR: state_nxt = i_tms ? SBS_EX2_IR : SBS_PAU_IR;
			SBS_EX2_IR: state_nxt = i_tms ? SBS_UPD_IR : SBS_SH_IR;
			SBS_UPD_IR: state_nxt = i_tms ? SBS_SEL_DR : SBS_RTI;
			default: state_nxt = SBS_TLR;
		endcase
	end

	assign tap.tlr = (state_r == SBS_TLR);
	assign tap.cap_dr = (state_r == SBS_CAP_DR);
	assign tap.sh_dr = (state_r == SBS_SH_DR);
	assign tap.upd_dr = (state_r == SBS_UPD_DR);
	assign tap.cap_ir = (state_r == SBS_CAP_IR);
	assign tap.sh_ir = (state_r == SBS_SH_IR);
	assign tap.upd_ir = (state_r == SBS_UPD_IR);
endmodule

/* design/sbs_tap_if.sv */
// State strobes from the TAP controller to the test data registers.
// Assumes both ends sit on the test clock.
`timescale 1ns/1ps
interface sbs_tap_if;
	logic tlr;
	logic cap_dr;
	logic sh_dr;
	logic upd_dr;
	logic cap_ir;
	logic sh_ir;
	logic upd_ir;
	modport ctl (output tlr, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
	modport usr (input tlr, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
endinterface

/* design/sbs_tap_top.sv */
// Boundary scan test data path: instruction, bypass, identify and ring.
// Assumes the test clock comes from the outside controller at up to
// 20 MHz and that ring states are raw ball levels, asynchronous to it.
`timescale 1ns/1ps
module sbs_tap_top
	import sbs_pkg::*;
#(
	// Arbitrary identity values, not those of any real part
	parameter logic [10:0] P_VENDOR_ID = 11'h155,
	parameter logic [16:0] P_PART_CFG = 17'h00a5a
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic [SBS_PIN_W-1:0] i_ring_state,
	output logic o_tdo,
	output logic o_tdo_oe,
	output logic [SBS_PIN_W-1:0] o_ring_preload,
	output logic o_extest,
	output logic o_rd_drive_en
);
	sbs_tap_if tap ();

	// Test clock domain: clock enable and ring synchronisers
	logic ce_meta_r;
	logic ce_tck_r;
	logic [SBS_PIN_W-1:0] ring_meta_r;
	logic [SBS_PIN_W-1:0] ring_sync_r;

	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			ce_meta_r <= 1'b0;
			ce_tck_r <= 1'b0;
		end else begin
			ce_meta_r <= i_ce;
			ce_tck_r <= ce_meta_r;
		end
	end

	// A ball that moves near capture can still read either way
	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			ring_meta_r <= {SBS_PIN_W{1'b0}};
			ring_sync_r <= {SBS_PIN_W{1'b0}};
		end else if (ce_tck_r) begin
			ring_meta_r <= i_ring_state;
			ring_sync_r <= ring_meta_r;
		end
	end

	sbs_tap_fsm u_fsm (
		.i_tck(i_tck),
		.i_resetn(i_resetn),
		.i_en(ce_tck_r),
		.i_tms(i_tms),
		.tap(tap.ctl)
	);

	// Instruction register
	wire [SBS_IR_W-1:0] active_op;
	wire ir_so;

	sbs_scan_chain #(
		.W(SBS_IR_W),
		.RST(SBS_IR_RESET)
	) u_ir (
		.i_clk(i_tck),
		.i_resetn(i_resetn),
		.i_en(ce_tck_r),
		.i_tlr(tap.tlr),
		.i_capture(tap.cap_ir),
		.i_shift(tap.sh_ir),
		.i_update(tap.upd_ir),
		.i_si(i_tdi),
		.i_cap_val(SBS_IR_CAPTURE),
		.o_so(ir_so),
		.o_par(active_op)
	);

	// Decode; reserved codes fall to the bypass bit
	wire op_extest = (active_op == SBS_OP_EXTEST);
	wire op_ident = (active_op == SBS_OP_IDENT);
	wire op_sample_z = (active_op == SBS_OP_SAMPLE_Z);
	wire op_preload = (active_op == SBS_OP_PRELOAD);
	wire sel_bsr = op_extest | op_sample_z | op_preload;
	wire sel_id = op_ident;
	wire sel_byp = !sel_bsr && !sel_id;

	// Boundary ring; the internal cell captures its own latched value
	wire [SBS_BSR_W-1:0] bsr_par;
	wire [SBS_BSR_W-1:0] bsr_cap = {bsr_par[SBS_OUTCTL_BIT], ring_sync_r};
	wire bsr_so;

	sbs_scan_chain #(
		.W(SBS_BSR_W),
		.RST(SBS_BSR_RESET)
	) u_bsr (
		.i_clk(i_tck),
		.i_resetn(i_resetn),
		.i_en(ce_tck_r),
		.i_tlr(tap.tlr),
		.i_capture(tap.cap_dr && sel_bsr),
		.i_shift(tap.sh_dr && sel_bsr),
		.i_update(tap.upd_dr && sel_bsr),
		.i_si(i_tdi),
		.i_cap_val(bsr_cap),
		.o_so(bsr_so),
		.o_par(bsr_par)
	);

	// Identify register and bypass bit
	wire [SBS_ID_W-1:0] id_code = {SBS_ID_REV, P_PART_CFG, P_VENDOR_ID, SBS_ID_START};
	logic [SBS_ID_W-1:0] id_r;
	logic byp_r;

	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			id_r <= {SBS_ID_W{1'b0}};
		end else if (ce_tck_r && tap.cap_dr && sel_id) begin
			id_r <= id_code;
		end else if (ce_tck_r && tap.sh_dr && sel_id) begin
			id_r <= {i_tdi, id_r[SBS_ID_W-1:1]};
		end
	end

	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			byp_r <= 1'b0;
		end else if (ce_tck_r && tap.cap_dr && sel_byp) begin
			byp_r <= 1'b0;
		end else if (ce_tck_r && tap.sh_dr && sel_byp) begin
			byp_r <= i_tdi;
		end
	end

	// Serial out on the falling edge
	wire dr_so = sel_bsr ? bsr_so : (sel_id ? id_r[0] : byp_r);
	wire tdo_nxt = tap.sh_ir ? ir_so : dr_so;
	wire tdo_oe_nxt = tap.sh_ir | tap.sh_dr;

	always_ff @(negedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tdo <= 1'b0;
			o_tdo_oe <= 1'b0;
		end else if (ce_tck_r) begin
			o_tdo <= tdo_nxt;
			o_tdo_oe <= tdo_oe_nxt;
		end
	end

	// Output control levels, taken on the falling test clock edge: the test clock may stop
	// right after the Update edge, and a rising-edge flop would then never pass the level on
	logic drive_en_tck_r;
	logic extest_tck_r;
	wire drive_en_nxt = op_extest ? bsr_par[SBS_OUTCTL_BIT] : !op_sample_z;

	always_ff @(negedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			drive_en_tck_r <= 1'b1;
			extest_tck_r <= 1'b0;
		end else if (ce_tck_r) begin
			drive_en_tck_r <= drive_en_nxt;
			extest_tck_r <= op_extest;
		end
	end

	// Pin pattern changes only at Update-DR and Test-Logic-Reset, so it stays quasi-static
	assign o_ring_preload = bsr_par[SBS_PIN_W-1:0];

	// Memory clock domain: two-flop crossing of the control levels
	logic drive_meta_r;
	logic drive_sync_r;
	logic extest_meta_r;
	logic extest_sync_r;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			drive_meta_r <= 1'b1;
			drive_sync_r <= 1'b1;
			extest_meta_r <= 1'b0;
			extest_sync_r <= 1'b0;
		end else if (i_ce) begin
			drive_meta_r <= drive_en_tck_r;
			drive_sync_r <= drive_meta_r;
			extest_meta_r <= extest_tck_r;
			extest_sync_r <= extest_meta_r;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_drive_en <= 1'b1;
			o_extest <= 1'b0;
		end else if (i_ce) begin
			o_rd_drive_en <= drive_sync_r;
			o_extest <= extest_sync_r;
		end
	end
endmodule

/* sim/sbs_jtag_ctl.sv */
// Behavioural test controller on the scan port.
// Assumes data-out is released whenever its enable is low.
`timescale 1ns/1ps
module sbs_jtag_ctl (
	input wire logic i_tdo,
	input wire logic i_tdo_oe,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	output logic [108:0] o_got,
	output logic o_rdy
);
	logic last = 1'b0;
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
		o_got = '0;
		o_rdy = 1'b0;
	end
	// Clock stands still between frames; each step is a fixed 48 ns period
	task step(input logic m, input logic d, output logic q);
		o_tms = m;
		o_tdi = d;
		#12 o_tck = 1'b1;
		// Sampled at the rising edge; a released line reads inverted
		q = i_tdo_oe ? i_tdo : ~last;
		last = q;
		#24 o_tck = 1'b0;
		#12;
	endtask
	task tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
	task scan(input logic ir, input int n, input logic [108:0] din);
		logic q;
		logic [108:0] g;
		g = '0;
		step(1'b1, 1'b1, q);
		if (ir) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			g[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		o_got = g;
		// Word settles before the strobe so the watcher never reads a stale word
		#1 o_rdy = ~o_rdy;
	endtask
endmodule

/* sim/sbs_tap_props.sv */
// Checker on the scan path top ports.
// Assumes i_ce is held high and tck stands still during reset.
`timescale 1ns/1ps
module sbs_tap_props (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic o_tdo,
	input wire logic o_tdo_oe,
	input wire logic o_extest,
	input wire logic o_rd_drive_en
);
	logic [1:0] pos_r;
	// Pre-edge value; a change at the rising edge shows at the next falling one
	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) pos_r <= 2'h0;
		else pos_r <= {o_tdo, o_tdo_oe};
	end
	sequence five_high;
		i_tms [*5];
	endsequence
	sequence into_ir;
		!i_tms && !o_tdo_oe ##1 i_tms [*2] ##1 !i_tms [*2];
	endsequence
	a_tdo_edge: assert property (@(negedge i_tck) disable iff (!i_resetn)
		{o_tdo, o_tdo_oe} == pos_r) else $error("tdo moved on rising tck");
	a_oe_enter: assert property (@(posedge i_tck) disable iff (!i_resetn)
		$rose(o_tdo_oe) |-> !$past(i_tms) && !$past(i_tms, 2)) else $error("oe outside shift");
	a_oe_leave: assert property (@(posedge i_tck) disable iff (!i_resetn)
		o_tdo_oe && i_tms |=> !o_tdo_oe) else $error("oe kept after shift");
	a_oe_hold: assert property (@(posedge i_tck) disable iff (!i_resetn)
		o_tdo_oe && !i_tms |=> o_tdo_oe) else $error("oe lost in shift");
	a_tap_reset: assert property (@(posedge i_tck) disable iff (!i_resetn)
		five_high |=> !o_tdo_oe) else $error("tap not reset");
	a_ir_capture: assert property (@(posedge i_tck) disable iff (!i_resetn)
		into_ir |=> o_tdo_oe -> o_tdo) else $error("ir capture bit0 not 1");
	a_reset_hiz: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(i_resetn) |-> !o_tdo_oe) else $error("tdo driven after reset");
	a_drive_preset: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(i_resetn) |-> o_rd_drive_en && !o_extest) else $error("drive preset wrong");
endmodule
bind sbs_tap_top sbs_tap_props u_sbs_tap_props (.i_sys_clk, .i_resetn, .i_tck, .i_tms, .o_tdo,
	.o_tdo_oe, .o_extest, .o_rd_drive_en);

/* sim/sbs_tap_top_test.sv */
// Self-checking bench for the boundary scan test data path.
// Assumes sbs_jtag_ctl drives the scan port; i_ce stays high.
`timescale 1ns/1ps
module sbs_tap_top_test;
	import sbs_pkg::*;
	// Arbitrary identity values
	localparam logic [10:0] VID = 11'h2b3;
	localparam logic [16:0] PCF = 17'h01c3d;
	localparam logic [31:0] ID = {3'h0, PCF, VID, 1'b1};
	localparam logic [2:0] BYP [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [SBS_PIN_W-1:0] ring = '0;
	logic [SBS_PIN_W-1:0] pre;
	logic tck, tms, tdi, tdo, oe, ext, drv, rdy;
	logic [108:0] got, p;
	logic [108:0] q_exp [$];
	logic [127:0] rnd;
	int mismatches = 0;
	int tests_run = 0;
	always #12.5 i_sys_clk = ~i_sys_clk;
	sbs_tap_top #(.P_VENDOR_ID(VID), .P_PART_CFG(PCF)) u_sbs_tap_top (.i_sys_clk, .i_resetn,
		.i_ce(1'b1), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_ring_state(ring), .o_tdo(tdo),
		.o_tdo_oe(oe), .o_ring_preload(pre), .o_extest(ext), .o_rd_drive_en(drv));
	sbs_jtag_ctl u_sbs_jtag_ctl (.i_tdo(tdo), .i_tdo_oe(oe), .o_tck(tck), .o_tms(tms),
		.o_tdi(tdi), .o_got(got), .o_rdy(rdy));
	task chk(input logic [108:0] g, input logic [108:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task end_sim();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(rdy) begin
		if (q_exp.size() > 0) chk(got, q_exp.pop_front());
	end
	task dr(input int n, input logic [108:0] d, input logic [108:0] e);
		q_exp.push_back(e);
		u_sbs_jtag_ctl.scan(1'b0, n, d);
	endtask
	task ir(input logic [2:0] c);
		q_exp.push_back(109'h1);
		u_sbs_jtag_ctl.scan(1'b1, 3, {106'h0, c});
		repeat (5) @(negedge i_sys_clk);
	endtask
	task rst();
		@(posedge i_sys_clk) i_resetn <= 1'b0;
		repeat (10) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		u_sbs_jtag_ctl.tap_reset();
	endtask
	initial begin
		void'($urandom(32'h2c09));
		rst();
		dr(32, '1, ID);
		foreach (BYP[k]) begin
			ir(BYP[k]); // Bypass code and reserved codes act as bypass
			p = $urandom();
			dr(8, p, {p[6:0], 1'b0});
		end
		// Ring held still across capture, test clock synchroniser pair included
		rnd = {$urandom(), $urandom(), $urandom(), $urandom()};
		@(posedge i_sys_clk) ring <= rnd[107:0];
		ir(SBS_OP_PRELOAD);
		rnd = {$urandom(), $urandom(), $urandom(), $urandom()};
		p = {1'b0, rnd[107:0]};
		dr(SBS_BSR_W, p, {1'b1, ring});
		chk(pre, p[107:0]);
		ir(SBS_OP_EXTEST);
		chk({ext, drv}, 2'h2);
		p[108] = 1'b1;
		dr(SBS_BSR_W, p, {1'b0, ring});
		repeat (5) @(negedge i_sys_clk);
		chk({ext, drv}, 2'h3);
		ir(SBS_OP_SAMPLE_Z);
		chk({ext, drv}, 2'h0);
		dr(SBS_BSR_W, p, {1'b1, ring});
		ir(SBS_OP_IDENT);
		chk({ext, drv}, 2'h1);
		ir(SBS_OP_EXTEST);
		u_sbs_jtag_ctl.tap_reset();
		repeat (5) @(negedge i_sys_clk);
		chk({ext, drv}, 2'h1);
		dr(32, '0, ID);
		rst();
		dr(32, '0, ID);
		// Let the watcher take the last note before closing
		repeat (2) @(negedge i_sys_clk);
		end_sim();
	end
	initial begin
		#1000000;
		mismatches++;
		end_sim();
	end
endmodule
